// [core/ch1_front.sv]
// Overview of operation
// [RULE_01] Direction 00 output, else capture source select
// [RULE_02] Direction writable only while channel disabled
// [RULE_03] Capture every 1, 2, 4, 8 events
// [RULE_04] Filter code picks divider and sample count
// [RULE_05] Level passes after N agreeing divided samples
// [RULE_06] Output mode: enable gates compare output
// [RULE_07] Input mode: enable gates counter capture
// [RULE_08] Output polarity: 0 high, 1 low active
// [RULE_09] Input polarity 00 rising, 01 falling
// [RULE_10] Auxiliary polarity held clear in output mode
// [RULE_11] Disabled: output and drive enable both low
// [RULE_12] Pattern 11 both edges, 10 reserved
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module ch1_front (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        timer_input_one,
	input  wire logic        timer_input_two,
	input  wire logic        internal_trigger_source,
	input  wire logic [15:0] counter_value,
	input  wire logic        compare_reference_level,
	output var  logic        compare_output_one,
	output var  logic        output_drive_enable,
	output var  logic        capture_event,
	output var  logic        filtered_edge_signal
);
	import ch1_front_pkg::*;

	typedef struct packed {
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		ch1_cfg_t    cfg;
		logic [15:0] capture_value;
		logic        overcapture;
		logic        captured;
		logic        prev_level;
		logic [2:0]  event_cnt;
		logic        cap_pulse;
		logic        out_level;
		logic        out_enable;
		logic        edge_level;
	} front_state_t;

	front_state_t state_ff;
	front_state_t nxt_state;
	logic         filt_level;
	logic         raw_sel;
	logic         edge_rise;
	logic         edge_fall;
	logic         qualified;
	logic [2:0]   div_mask;
	logic         is_input;
	logic [31:0]  rd_word;
	logic         wr_go;

	// -----------------------------------------------------------------
	// Input source selection and conditioning
	// -----------------------------------------------------------------
	always_comb begin
		unique case (state_ff.cfg.direction)
			DIR_TI_ONE:  raw_sel = timer_input_one;          // [RULE_01]
			DIR_TI_TWO:  raw_sel = timer_input_two;          // [RULE_01]
			DIR_TRIGGER: raw_sel = internal_trigger_source;  // [RULE_01]
			DIR_OUTPUT:  raw_sel = 1'b0;                     // [RULE_01]
		endcase
	end

	ch1_input_filter u_filter (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.raw_in       (raw_sel),
		.filter_code  (state_ff.cfg.input_filter),
		.filtered_out (filt_level)
	);

	function automatic logic [31:0] read_mux(input logic [7:0] a,
			input front_state_t s);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			ADDR_INPUT_MODE_SETUP: d = {24'h00_0000, s.cfg.input_filter,
				s.cfg.capture_divider, s.cfg.direction};
			ADDR_ENABLE_POLARITY: d = {28'h000_0000, s.cfg.polarity_aux,
				1'b0, s.cfg.polarity, s.cfg.enable};
			ADDR_CAPTURE_VALUE: d = {16'h0000, s.capture_value};
			ADDR_CHANNEL_STATUS: d = {29'h0000_0000, s.prev_level,
				s.overcapture, s.captured};
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction : read_mux

	function automatic logic known_addr(input logic [7:0] a);
		return a == ADDR_INPUT_MODE_SETUP || a == ADDR_ENABLE_POLARITY ||
			a == ADDR_CAPTURE_VALUE || a == ADDR_CHANNEL_STATUS;
	endfunction : known_addr

	assign is_input  = (state_ff.cfg.direction != DIR_OUTPUT);
	assign edge_rise = filt_level && !state_ff.prev_level;
	assign edge_fall = !filt_level && state_ff.prev_level;
	assign rd_word   = read_mux(s_axi_araddr, state_ff);
	assign wr_go     = state_ff.aw_held && state_ff.w_held &&
		!state_ff.bvalid;

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_state.cap_pulse  = 1'b0;
		nxt_state.prev_level = filt_level;

		// Edge choice from the two polarity bits.
		unique case ({state_ff.cfg.polarity_aux, state_ff.cfg.polarity})
			2'b00: qualified = edge_rise;              // [RULE_09]
			2'b01: qualified = edge_fall;              // [RULE_09]
			2'b11: qualified = edge_rise || edge_fall; // [RULE_12]
			2'b10: qualified = 1'b0;                   // [RULE_12]
		endcase
		// Only pattern 01 inverts; 11 senses both edges uninverted.
		nxt_state.edge_level = ({state_ff.cfg.polarity_aux,
			state_ff.cfg.polarity} == 2'b01) ?
			!filt_level : filt_level;             // [RULE_09] [RULE_12]

		unique case (state_ff.cfg.capture_divider)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			2'h3: div_mask = 3'h7;
		endcase

		// Events are counted even while capture is gated, so the
		// divider phase is kept; only the copy is blocked.
		if (is_input && qualified) begin
			nxt_state.event_cnt = (state_ff.event_cnt + 3'h1) & div_mask;
			if (state_ff.event_cnt == div_mask) begin // [RULE_03]
				if (state_ff.cfg.enable) begin // [RULE_07]
					nxt_state.capture_value = counter_value; // [RULE_07]
					nxt_state.cap_pulse     = 1'b1;
					nxt_state.captured      = 1'b1;
					if (state_ff.captured) begin
						nxt_state.overcapture = 1'b1;
					end
				end
			end
		end else if (!is_input) begin
			nxt_state.event_cnt = 3'h0;
		end

		// Output stage: disabled or input means pin low and not driven.
		if (!is_input && state_ff.cfg.enable) begin // [RULE_06]
			nxt_state.out_level  = compare_reference_level ^
				state_ff.cfg.polarity; // [RULE_08] [RULE_11]
			nxt_state.out_enable = 1'b1; // [RULE_11]
		end else begin
			nxt_state.out_level  = 1'b0; // [RULE_11]
			nxt_state.out_enable = 1'b0; // [RULE_11]
		end

		// AXI4-Lite write channels, taken in either order.
		if (s_axi_awvalid && !state_ff.aw_held) begin
			nxt_state.aw_held = 1'b1;
			nxt_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_ff.w_held) begin
			nxt_state.w_held = 1'b1;
			nxt_state.w_data = s_axi_wdata;
			nxt_state.w_strb = s_axi_wstrb;
		end
		if (wr_go) begin
			nxt_state.aw_held = 1'b0;
			nxt_state.w_held  = 1'b0;
			nxt_state.bvalid  = 1'b1;
			nxt_state.bresp   = known_addr(state_ff.aw_addr) ?
				RESP_OKAY : RESP_SLVERR;
			if (state_ff.w_strb[0]) begin
				unique case (state_ff.aw_addr)
					ADDR_INPUT_MODE_SETUP: begin
						if (!state_ff.cfg.enable) begin // [RULE_02]
							nxt_state.cfg.direction = state_ff.w_data[DIR_LSB +: 2];
						end
						nxt_state.cfg.capture_divider =
							state_ff.w_data[CAPDIV_LSB +: 2];
						nxt_state.cfg.input_filter    =
							state_ff.w_data[FILT_LSB +: 4];
						nxt_state.event_cnt           = 3'h0;
					end
					ADDR_ENABLE_POLARITY: begin
						nxt_state.cfg.enable       = state_ff.w_data[EN_BIT];
						nxt_state.cfg.polarity     = state_ff.w_data[POL_BIT];
						nxt_state.cfg.polarity_aux =
							state_ff.w_data[POLAUX_BIT];
					end
					ADDR_CHANNEL_STATUS: begin
						// Write one to clear; a new capture wins.
						if (state_ff.w_data[0] && !nxt_state.cap_pulse) begin
							nxt_state.captured = 1'b0;
						end
						if (state_ff.w_data[1] && !nxt_state.cap_pulse) begin
							nxt_state.overcapture = 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
		end
		if (state_ff.bvalid && s_axi_bready) begin
			nxt_state.bvalid = 1'b0;
		end

		// Auxiliary polarity is forced clear in output mode.
		if (nxt_state.cfg.direction == DIR_OUTPUT) begin
			nxt_state.cfg.polarity_aux = 1'b0; // [RULE_10]
		end

		// AXI4-Lite read: one-cycle answer held until rready.
		if (state_ff.rvalid) begin
			if (s_axi_rready) begin
				nxt_state.rvalid = 1'b0;
			end
		end else if (s_axi_arvalid) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rdata  = rd_word;
			nxt_state.rresp  = known_addr(s_axi_araddr) ?
				RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign s_axi_awready       = !state_ff.aw_held;
	assign s_axi_wready        = !state_ff.w_held;
	assign s_axi_bvalid        = state_ff.bvalid;
	assign s_axi_bresp         = state_ff.bresp;
	assign s_axi_arready       = !state_ff.rvalid;
	assign s_axi_rvalid        = state_ff.rvalid;
	assign s_axi_rdata         = state_ff.rdata;
	assign s_axi_rresp         = state_ff.rresp;
	assign compare_output_one  = state_ff.out_level;
	assign output_drive_enable = state_ff.out_enable;
	assign capture_event       = state_ff.cap_pulse;
	assign filtered_edge_signal = state_ff.edge_level;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	dir_locked_a: assert property (state_ff.cfg.enable |=> // [RULE_02]
		state_ff.cfg.direction == $past(state_ff.cfg.direction))
		else $error("direction changed while enabled");
	off_output_low_a: assert property (!state_ff.cfg.enable |=> // [RULE_11]
		!output_drive_enable && !compare_output_one)
		else $error("disabled output still driven");
	out_polarity_a: assert property ( // [RULE_08]
		(!is_input && state_ff.cfg.enable) |=> output_drive_enable &&
		compare_output_one == ($past(compare_reference_level) ^
		$past(state_ff.cfg.polarity)))
		else $error("output level wrong for polarity");
	aux_clear_a: assert property ( // [RULE_10]
		!is_input |-> !state_ff.cfg.polarity_aux)
		else $error("aux polarity set in output mode");
	capture_gate_a: assert property (capture_event |-> // [RULE_07]
		$past(state_ff.cfg.enable) && $past(is_input))
		else $error("capture while gated");
	capture_copy_a: assert property (capture_event |-> // [RULE_07]
		state_ff.capture_value == $past(counter_value))
		else $error("capture value wrong");
	divider_phase_a: assert property (capture_event |-> // [RULE_03]
		$past(state_ff.event_cnt) == $past(div_mask))
		else $error("capture off divider phase");
	no_output_input_a: assert property ( // [RULE_06]
		is_input |=> !output_drive_enable)
		else $error("input channel drives output");
	source_sel_a: assert property ( // [RULE_01]
		state_ff.cfg.direction == DIR_TI_TWO |-> raw_sel == timer_input_two)
		else $error("wrong capture source");
	reserved_edge_a: assert property ( // [RULE_12]
		(is_input && state_ff.cfg.polarity_aux && !state_ff.cfg.polarity)
		|=> !capture_event)
		else $error("capture with reserved polarity");
	falling_a: assert property ( // [RULE_09]
		(is_input && state_ff.cfg.enable &&
		state_ff.cfg.capture_divider == 2'h0 &&
		{state_ff.cfg.polarity_aux, state_ff.cfg.polarity} == 2'b01 &&
		edge_fall) |=> capture_event)
		else $error("falling edge not captured");

	cover property (capture_event);
	cover property (state_ff.cfg.capture_divider == 2'h3 && capture_event);
	cover property (output_drive_enable && compare_output_one);
	cover property (state_ff.bvalid && state_ff.bresp == RESP_SLVERR);

endmodule : ch1_front
`default_nettype wire

// [core/ch1_front_pkg.sv]
package ch1_front_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_INPUT_MODE_SETUP   = 8'h18;
	localparam logic [7:0] ADDR_ENABLE_POLARITY    = 8'h20;
	localparam logic [7:0] ADDR_CAPTURE_VALUE      = 8'h34;
	localparam logic [7:0] ADDR_CHANNEL_STATUS     = 8'h40;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int DIR_LSB     = 0;
	localparam int CAPDIV_LSB  = 2;
	localparam int FILT_LSB    = 4;
	localparam int EN_BIT      = 0;
	localparam int POL_BIT     = 1;
	localparam int POLAUX_BIT  = 3;

	// ---------------------------------------------------------------
	// Reset values and encodings
	// ---------------------------------------------------------------
	localparam logic [15:0] SETUP_RESET  = 16'h0000;
	localparam logic [15:0] ENPOL_RESET  = 16'h0000;
	localparam logic [1:0]  DIR_OUTPUT   = 2'h0;
	localparam logic [1:0]  DIR_TI_ONE   = 2'h1;
	localparam logic [1:0]  DIR_TI_TWO   = 2'h2;
	localparam logic [1:0]  DIR_TRIGGER  = 2'h3;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] direction;
		logic [1:0] capture_divider;
		logic [3:0] input_filter;
		logic       enable;
		logic       polarity;
		logic       polarity_aux;
	} ch1_cfg_t;

	typedef struct packed {
		logic [5:0] divider;
		logic [3:0] length;
	} filt_sel_t;

	// Filter code to sampling divider and required agreeing samples.
	function automatic filt_sel_t filter_decode(input logic [3:0] code);
		filt_sel_t s;
		s = '{divider: 6'h01, length: 4'h1};
		unique case (code)
			4'h0: s = '{divider: 6'h01, length: 4'h1};
			4'h1: s = '{divider: 6'h01, length: 4'h2};
			4'h2: s = '{divider: 6'h01, length: 4'h4};
			4'h3: s = '{divider: 6'h01, length: 4'h8};
			4'h4: s = '{divider: 6'h02, length: 4'h6};
			4'h5: s = '{divider: 6'h02, length: 4'h8};
			4'h6: s = '{divider: 6'h04, length: 4'h6};
			4'h7: s = '{divider: 6'h04, length: 4'h8};
			4'h8: s = '{divider: 6'h08, length: 4'h6};
			4'h9: s = '{divider: 6'h08, length: 4'h8};
			4'ha: s = '{divider: 6'h10, length: 4'h5};
			4'hb: s = '{divider: 6'h10, length: 4'h5};
			4'hc: s = '{divider: 6'h10, length: 4'h8};
			4'hd: s = '{divider: 6'h20, length: 4'h5};
			4'he: s = '{divider: 6'h20, length: 4'h8};
			4'hf: s = '{divider: 6'h20, length: 4'h8};
		endcase
		return s;
	endfunction : filter_decode

endpackage : ch1_front_pkg

// [core/ch1_input_filter.sv]
`timescale 1ns/1ps
`default_nettype none

module ch1_input_filter (
	input  wire logic                      core_clk,
	input  wire logic                      reset_n,
	input  wire logic                      raw_in,
	input  wire logic [3:0]                filter_code,
	output var  logic                      filtered_out
);
	import ch1_front_pkg::*;

	typedef struct packed {
		logic [5:0] div_cnt;
		logic [3:0] agree_cnt;
		logic       level;
	} filt_state_t;

	filt_state_t state_ff;
	filt_state_t nxt_state;
	filt_sel_t   sel;
	logic        sample_en;

	// -----------------------------------------------------------------
	// Sampling enable and agreement counter
	// -----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		sel       = filter_decode(filter_code);
		sample_en = (state_ff.div_cnt >= sel.divider - 6'h01); // [RULE_05]
		if (sample_en) begin
			nxt_state.div_cnt = 6'h00;
		end else begin
			nxt_state.div_cnt = state_ff.div_cnt + 6'h01;
		end
		if (filter_code == 4'h0) begin
			// Bypass: follow the pin at the base sampling rate.
			nxt_state.level     = raw_in; // [RULE_04]
			nxt_state.agree_cnt = 4'h0;
		end else if (sample_en) begin
			if (raw_in == state_ff.level) begin
				nxt_state.agree_cnt = 4'h0;
			end else if (state_ff.agree_cnt + 4'h1 >= sel.length) begin
				nxt_state.level     = raw_in; // [RULE_05]
				nxt_state.agree_cnt = 4'h0;
			end else begin
				nxt_state.agree_cnt = state_ff.agree_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign filtered_out = state_ff.level;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	bypass_follows_a: assert property (@(posedge core_clk) // [RULE_04]
		disable iff (!reset_n)
		(filter_code == 4'h0) ##1 (filter_code == 4'h0)
		|-> filtered_out == $past(raw_in))
		else $error("bypass filter did not follow input");
	stable_input_a: assert property (@(posedge core_clk) // [RULE_05]
		disable iff (!reset_n)
		(filter_code == 4'h1 && raw_in != filtered_out) ##1
		(filter_code == 4'h1 && raw_in != $past(raw_in))
		|=> $stable(filtered_out))
		else $error("filter passed a glitch");
	cover property (@(posedge core_clk) disable iff (!reset_n)
		filter_code != 4'h0 && $changed(filtered_out));

endmodule : ch1_input_filter
`default_nettype wire

// [test/ch1_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ch1_pin_model (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] drive_sel,
	input  wire logic       drive_level,
	output logic            timer_input_one,
	output logic            timer_input_two,
	output logic            internal_trigger_source
);
	logic [2:0] pins_ff;

	// Pins move only just after an edge, so a level seen by the filter is
	// never half way through a change.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pins_ff <= 3'h0;
		end else if (drive_sel != 2'h0) begin
			pins_ff[drive_sel - 2'h1] <= drive_level;
		end
	end

	assign timer_input_one         = pins_ff[0];
	assign timer_input_two         = pins_ff[1];
	assign internal_trigger_source = pins_ff[2];
endmodule : ch1_pin_model

`default_nettype wire

// [test/timer_ch1_capture_input_and_enable_test.sv]
`timescale 1ns/1ps
`default_nettype none

module timer_ch1_capture_input_and_enable_test;
	import ch1_front_pkg::*;

	logic        core_clk, reset_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, drive_sel;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, drive_level;
	logic        ti_one, ti_two, trig, ref_level, out_one, drive_en;
	logic        capture_event, edge_sig;
	logic [15:0] counter_value;
	int          num_errors, num_checks, cap_count, base;
	int          div_tab[4] = '{1, 2, 8, 32};
	int          len_tab[4] = '{2, 6, 8, 8};
	logic [3:0]  code_tab[4] = '{4'h1, 4'h4, 4'h9, 4'he};
	int          rise_tab[4] = '{1, 0, 0, 1};
	int          all_tab[4] = '{1, 1, 0, 2};

	ch1_front i_dut (
		.core_clk(core_clk), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .timer_input_one(ti_one),
		.timer_input_two(ti_two), .internal_trigger_source(trig),
		.counter_value(counter_value), .compare_reference_level(ref_level),
		.compare_output_one(out_one), .output_drive_enable(drive_en),
		.capture_event(capture_event), .filtered_edge_signal(edge_sig)
	);

	ch1_pin_model i_pins (
		.core_clk(core_clk), .reset_n(reset_n), .drive_sel(drive_sel),
		.drive_level(drive_level), .timer_input_one(ti_one),
		.timer_input_two(ti_two), .internal_trigger_source(trig)
	);

	always #2.5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		if (capture_event === 1'b1) begin
			cap_count <= cap_count + 1;
		end
	end

	// ---------------------------------------------------------------
	// Bus and pin tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] e,
			input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask : chk

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
			input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		if (er == RESP_OKAY) chk("rdata", ed, s_axi_rdata);
		s_axi_rready <= 1'b0;
	endtask : axi_read

	// Pin level holds n + 1 cycles before the next call can move it.
	task automatic pin(input logic [1:0] s, input logic l, input int n);
		@(posedge core_clk);
		drive_sel <= s;
		drive_level <= l;
		repeat (n) @(posedge core_clk);
	endtask : pin

	task automatic cfg(input logic [1:0] dir, input logic [1:0] dv,
			input logic [3:0] f, input logic [1:0] p);
		axi_write(ADDR_ENABLE_POLARITY, 32'h0, RESP_OKAY);
		axi_write(ADDR_INPUT_MODE_SETUP, {24'h0, f, dv, dir}, RESP_OKAY);
		axi_write(ADDR_ENABLE_POLARITY, {28'h0, p[1], 1'b0, p[0], 1'b1},
			RESP_OKAY);
	endtask : cfg

	task automatic stop_test();
		$display("checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		{core_clk, reset_n, s_axi_awaddr, s_axi_araddr, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_wdata, s_axi_wstrb, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, drive_sel, drive_level} = '0;
		{ref_level, counter_value, num_errors, num_checks, cap_count} = '0;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		axi_read(ADDR_INPUT_MODE_SETUP, {16'h0, SETUP_RESET}, RESP_OKAY);
		axi_read(ADDR_ENABLE_POLARITY, {16'h0, ENPOL_RESET}, RESP_OKAY);
		axi_read(8'h44, 32'h0, RESP_SLVERR);
		axi_write(8'h44, 32'h1, RESP_SLVERR);
		ref_level <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("out off", 32'h0, {30'h0, out_one, drive_en});
		axi_write(ADDR_ENABLE_POLARITY, 32'h1, RESP_OKAY);
		repeat (4) @(posedge core_clk);
		chk("out on", 32'h3, {30'h0, out_one, drive_en});
		axi_write(ADDR_ENABLE_POLARITY, 32'h3, RESP_OKAY);
		repeat (4) @(posedge core_clk);
		chk("out low act", 32'h1, {30'h0, out_one, drive_en});
		ref_level <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("out low idle", 32'h3, {30'h0, out_one, drive_en});
		axi_write(ADDR_ENABLE_POLARITY, 32'h9, RESP_OKAY);
		axi_read(ADDR_ENABLE_POLARITY, 32'h1, RESP_OKAY);
		axi_write(ADDR_INPUT_MODE_SETUP, {30'h0, DIR_TI_ONE}, RESP_OKAY);
		axi_read(ADDR_INPUT_MODE_SETUP, 32'h0, RESP_OKAY);
		axi_write(ADDR_ENABLE_POLARITY, 32'h0, RESP_OKAY);
		axi_write(ADDR_INPUT_MODE_SETUP, {30'h0, DIR_TI_ONE}, RESP_OKAY);
		axi_read(ADDR_INPUT_MODE_SETUP, 32'h1, RESP_OKAY);
		// Each source must capture its own pin and ignore a neighbour.
		for (int d = 1; d < 4; d++) begin
			cfg(d[1:0], 2'h0, 4'h0, 2'h0);
			counter_value <= 16'h1230 + 16'(d);
			base = cap_count;
			pin(d[1:0], 1'b1, 8);
			pin(d[1:0], 1'b0, 8);
			pin((d == 1) ? 2'h2 : 2'h1, 1'b1, 8);
			pin((d == 1) ? 2'h2 : 2'h1, 1'b0, 8);
			chk("source captures", 32'h1, cap_count - base);
			axi_read(ADDR_CAPTURE_VALUE, 32'h1230 + d, RESP_OKAY);
		end
		// Three captures without a clear leave both status flags set.
		axi_read(ADDR_CHANNEL_STATUS, 32'h3, RESP_OKAY);
		axi_write(ADDR_CHANNEL_STATUS, 32'h3, RESP_OKAY);
		axi_read(ADDR_CHANNEL_STATUS, 32'h0, RESP_OKAY);
		cfg(DIR_TI_ONE, 2'h0, 4'h0, 2'h0);
		axi_write(ADDR_ENABLE_POLARITY, 32'h0, RESP_OKAY);
		base = cap_count;
		pin(2'h1, 1'b1, 8);
		pin(2'h1, 1'b0, 8);
		chk("disabled captures", 32'h0, cap_count - base);
		for (int k = 0; k < 4; k++) begin
			cfg(DIR_TI_ONE, k[1:0], 4'h0, 2'h0);
			base = cap_count;
			repeat (8) begin
				pin(2'h1, 1'b1, 6);
				pin(2'h1, 1'b0, 6);
			end
			chk("divided captures", 32'(8 >> k), cap_count - base);
		end
		for (int p = 0; p < 4; p++) begin
			cfg(DIR_TI_ONE, 2'h0, 4'h0, p[1:0]);
			base = cap_count;
			pin(2'h1, 1'b1, 8);
			chk("rise captures", 32'(rise_tab[p]), cap_count - base);
			chk("edge level", {31'h0, p != 1}, {31'h0, edge_sig});
			pin(2'h1, 1'b0, 8);
			chk("edge captures", 32'(all_tab[p]), cap_count - base);
		end
		// A glitch one sample short must die; a long pulse must pass.
		for (int c = 0; c < 4; c++) begin
			cfg(DIR_TI_ONE, 2'h0, code_tab[c], 2'h0);
			base = cap_count;
			pin(2'h1, 1'b1, div_tab[c] * (len_tab[c] - 1) - 1);
			pin(2'h1, 1'b0, div_tab[c] * len_tab[c] + 16);
			chk("glitch captures", 32'h0, cap_count - base);
			pin(2'h1, 1'b1, div_tab[c] * (len_tab[c] + 2) + 8);
			pin(2'h1, 1'b0, div_tab[c] * len_tab[c] + 16);
			chk("filtered captures", 32'h1, cap_count - base);
		end
		stop_test();
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		num_errors++;
		stop_test();
	end
endmodule : timer_ch1_capture_input_and_enable_test

`default_nettype wire
